// File: inc/record_fmt_pkg.sv
// Constants, types and register map of the result record formatter.
// Function
// - Serial tabular setting on makes serial records come out as table lines.
// - Serial table lines end with return, line feed, then NUL padding.
// - Table columns: first, second, error one, error two, time.
// - A control bit decides whether the heading line is sent.
// - Listing stored results on serial adds an index number column.
// - Bus ASCII selection with talk-only on sends printer table lines.
// - Short bus table drops time; long matches the serial layout.
// - Bus ASCII selection with talk-only off sends compressed records.
// - Compressed parameter: sign, six digits with point, E, signed exponent.
// - Compressed time is four digit pairs: hours, minutes, seconds, hundredths.
// - Long compressed record: fields with separators, terminator at the end.
// - Short compressed record ends with terminator right after error two.
// - Dump parameters are four-byte floating-point values.
// - Dump errors are one BCD byte; time is four BCD bytes.
// - Long dump order: first, second, error one, error two, time.
// - Serial dump records equal the long bus dump record.
// - Dump records carry no separators and no terminators.
// - Bus dump raises end flag with last byte when terminator includes it.
// - Short dump drops the time bytes and keeps the rest.
// - Top bit of dump byte one is the sign, one for negative.
// - Low seven bits of byte one are a two's-complement exponent.
// - Bytes two to four are a fraction below one, binary point first.
package record_fmt_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] FIRST_BIN_OFS = 8'h08;
	localparam logic [7:0] SECOND_BIN_OFS = 8'h0C;
	localparam logic [7:0] FIRST_DEC_OFS = 8'h10;
	localparam logic [7:0] SECOND_DEC_OFS = 8'h14;
	localparam logic [7:0] ERRORS_OFS = 8'h18;
	localparam logic [7:0] TIME_OFS = 8'h1C;
	localparam logic [7:0] INDEX_OFS = 8'h20;
	localparam logic [7:0] START_OFS = 8'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_BUS_MODE_LSB = 0;
	localparam int CTRL_SER_MODE_LSB = 3;
	localparam int CTRL_TALK_ONLY_BIT = 5;
	localparam int CTRL_HEAD_BIT = 6;
	localparam int CTRL_LIST_BIT = 7;
	localparam int CTRL_PORT_BIT = 8;
	localparam int CTRL_TERM_LSB = 12;
	localparam int CTRL_SEP_LSB = 16;
	localparam int ERR_FIRST_EXP_NEG_BIT = 16;
	localparam int ERR_SECOND_EXP_NEG_BIT = 17;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_REFUSED_BIT = 1;
	localparam int STATUS_FIELD_LSB = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CTRL_RESET = 32'h002C0040;
	localparam logic [31:0] DATA_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Modes, terminators, record fields
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BUS_OFF = 3'b000,
		BUS_LONG_ASCII = 3'b001,
		BUS_SHORT_ASCII = 3'b010,
		BUS_LONG_DUMP = 3'b011,
		BUS_SHORT_DUMP = 3'b100
	} bus_mode_t;

	typedef enum logic [1:0] {
		SER_OFF = 2'b00,
		SER_TABULAR = 2'b01,
		SER_DUMP = 2'b10
	} ser_mode_t;

	typedef enum logic [2:0] {
		TERM_RETURN_NEWLINE = 3'b000,
		TERM_RETURN = 3'b001,
		TERM_NEWLINE = 3'b010,
		TERM_RETURN_WITH_END_FLAG = 3'b011,
		TERM_RETURN_NEWLINE_END_FLAG = 3'b100
	} term_t;

	typedef enum logic [1:0] {
		FMT_TABLE = 2'b00,
		FMT_COMPRESSED = 2'b01,
		FMT_DUMP = 2'b10
	} fmt_t;

	typedef enum logic [3:0] {
		FLD_FIRST = 4'b0000,
		FLD_SECOND = 4'b0001,
		FLD_ERR_ONE = 4'b0010,
		FLD_ERR_TWO = 4'b0011,
		FLD_TIME = 4'b0100,
		FLD_INDEX = 4'b0101,
		FLD_SEP = 4'b0110,
		FLD_TERM = 4'b0111,
		FLD_HEAD_BASE = 4'b1000,
		FLD_HEAD_TIME = 4'b1001,
		FLD_HEAD_INDEX = 4'b1010
	} field_t;

	// ----------------------------------------------------------------
	// Characters and field lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_POINT = 8'h2E;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [3:0] DIGIT_ZONE = 4'h3;
	localparam logic [4:0] LEN_ASCII_PARAM = 5'h0C;
	localparam logic [4:0] LEN_DUMP_PARAM = 5'h04;
	localparam logic [4:0] LEN_ASCII_ERR = 5'h02;
	localparam logic [4:0] LEN_DUMP_ERR = 5'h01;
	localparam logic [4:0] LEN_ASCII_TIME = 5'h0B;
	localparam logic [4:0] LEN_DUMP_TIME = 5'h04;
	localparam logic [4:0] LEN_INDEX = 5'h04;
	localparam logic [4:0] LEN_HEAD_BASE = 5'h12;
	localparam logic [4:0] LEN_HEAD_TIME = 5'h05;
	localparam logic [4:0] LEN_HEAD_INDEX = 5'h07;
	localparam logic [8*18-1:0] HEAD_BASE_TEXT = "FIRST SECOND E1 E2";
	localparam logic [8*5-1:0] HEAD_TIME_TEXT = " TIME";
	localparam logic [8*7-1:0] HEAD_INDEX_TEXT = " NUMBER";
	localparam int NUL_PAD_DEFAULT = 4;

endpackage

// File: rtl/result_record_formatter.sv
// Result record formatter with a Wishbone register slave and two byte ports.
`timescale 1ns/1ps

module result_record_formatter
#(
	parameter int NUL_PAD = record_fmt_pkg::NUL_PAD_DEFAULT
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] ser_data_o,
	output logic ser_valid_o,
	input wire logic ser_ready_i,
	output logic [7:0] bus_data_o,
	output logic bus_valid_o,
	output logic bus_eoi_o,
	input wire logic bus_ready_i
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] first_bin;
		logic [31:0] second_bin;
		logic [31:0] first_dec;
		logic [31:0] second_dec;
		logic [31:0] err;
		logic [31:0] tim;
		logic [15:0] idx;
		logic head_pend;
		logic refused;
		logic run;
		logic on_bus;
		record_fmt_pkg::fmt_t fmt;
		record_fmt_pkg::term_t term;
		logic [7:0] sep;
		record_fmt_pkg::field_t [15:0] fl;
		logic [4:0] cnt;
		logic [4:0] fi;
		logic [4:0] pos;
		logic [7:0] ser_data;
		logic ser_valid;
		logic [7:0] bus_data;
		logic bus_valid;
		logic bus_eoi;
		logic ack;
		logic [31:0] dat;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				r[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] dig(input logic [3:0] d);
		return {record_fmt_pkg::DIGIT_ZONE, d};
	endfunction

	function automatic logic [7:0] word_byte(input logic [31:0] w,
		input logic [1:0] p);
		logic [7:0] r;
		case (p)
			2'b00: r = w[31:24];
			2'b01: r = w[23:16];
			2'b10: r = w[15:8];
			default: r = w[7:0];
		endcase
		return r;
	endfunction

	function automatic logic [4:0] len_of(input state_t s);
		logic [4:0] r;
		logic dump;
		dump = (s.fmt == record_fmt_pkg::FMT_DUMP);
		case (s.fl[s.fi])
			record_fmt_pkg::FLD_FIRST, record_fmt_pkg::FLD_SECOND:
				r = dump ? record_fmt_pkg::LEN_DUMP_PARAM
					: record_fmt_pkg::LEN_ASCII_PARAM;
			record_fmt_pkg::FLD_ERR_ONE, record_fmt_pkg::FLD_ERR_TWO:
				r = dump ? record_fmt_pkg::LEN_DUMP_ERR
					: record_fmt_pkg::LEN_ASCII_ERR;
			record_fmt_pkg::FLD_TIME:
				r = dump ? record_fmt_pkg::LEN_DUMP_TIME
					: record_fmt_pkg::LEN_ASCII_TIME;
			record_fmt_pkg::FLD_INDEX: r = record_fmt_pkg::LEN_INDEX;
			record_fmt_pkg::FLD_HEAD_BASE: r = record_fmt_pkg::LEN_HEAD_BASE;
			record_fmt_pkg::FLD_HEAD_TIME: r = record_fmt_pkg::LEN_HEAD_TIME;
			record_fmt_pkg::FLD_HEAD_INDEX: r = record_fmt_pkg::LEN_HEAD_INDEX;
			record_fmt_pkg::FLD_TERM:
			begin
				if (!s.on_bus)
				begin
					r = 5'(2 + NUL_PAD);
				end
				else if (s.term == record_fmt_pkg::TERM_RETURN_NEWLINE ||
					s.term == record_fmt_pkg::TERM_RETURN_NEWLINE_END_FLAG)
				begin
					r = 5'h02;
				end
				else
				begin
					r = 5'h01;
				end
			end
			default: r = 5'h01;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] param_byte(input state_t s,
		input logic [31:0] bin, input logic [31:0] dec, input logic eneg);
		logic [7:0] r;
		if (s.fmt == record_fmt_pkg::FMT_DUMP)
		begin
			// Sign, exponent and fraction arrive already packed.
			r = word_byte(bin, s.pos[1:0]);
		end
		else
		begin
			case (s.pos)
				5'h00: r = bin[31] ? record_fmt_pkg::CH_MINUS
					: record_fmt_pkg::CH_PLUS;
				5'h01: r = dig(dec[23:20]);
				5'h02: r = record_fmt_pkg::CH_POINT;
				5'h03: r = dig(dec[19:16]);
				5'h04: r = dig(dec[15:12]);
				5'h05: r = dig(dec[11:8]);
				5'h06: r = dig(dec[7:4]);
				5'h07: r = dig(dec[3:0]);
				5'h08: r = record_fmt_pkg::CH_E;
				5'h09: r = eneg ? record_fmt_pkg::CH_MINUS
					: record_fmt_pkg::CH_PLUS;
				5'h0A: r = dig(dec[31:28]);
				default: r = dig(dec[27:24]);
			endcase
		end
		return r;
	endfunction

	function automatic logic [7:0] time_byte(input state_t s);
		logic [7:0] r;
		logic comp;
		comp = (s.fmt == record_fmt_pkg::FMT_COMPRESSED);
		if (s.fmt == record_fmt_pkg::FMT_DUMP)
		begin
			r = word_byte(s.tim, s.pos[1:0]);
		end
		else
		begin
			case (s.pos)
				5'h00: r = dig(s.tim[31:28]);
				5'h01: r = dig(s.tim[27:24]);
				5'h02: r = comp ? s.sep : record_fmt_pkg::CH_COLON;
				5'h03: r = dig(s.tim[23:20]);
				5'h04: r = dig(s.tim[19:16]);
				5'h05: r = comp ? s.sep : record_fmt_pkg::CH_COLON;
				5'h06: r = dig(s.tim[15:12]);
				5'h07: r = dig(s.tim[11:8]);
				5'h08: r = comp ? s.sep : record_fmt_pkg::CH_POINT;
				5'h09: r = dig(s.tim[7:4]);
				default: r = dig(s.tim[3:0]);
			endcase
		end
		return r;
	endfunction

	function automatic logic [7:0] byte_of(input state_t s);
		logic [7:0] r;
		int k;
		k = 0;
		case (s.fl[s.fi])
			record_fmt_pkg::FLD_FIRST:
				r = param_byte(s, s.first_bin, s.first_dec,
					s.err[record_fmt_pkg::ERR_FIRST_EXP_NEG_BIT]);
			record_fmt_pkg::FLD_SECOND:
				r = param_byte(s, s.second_bin, s.second_dec,
					s.err[record_fmt_pkg::ERR_SECOND_EXP_NEG_BIT]);
			record_fmt_pkg::FLD_ERR_ONE:
				r = (s.fmt == record_fmt_pkg::FMT_DUMP) ? s.err[7:0]
					: dig(s.pos[0] ? s.err[3:0] : s.err[7:4]);
			record_fmt_pkg::FLD_ERR_TWO:
				r = (s.fmt == record_fmt_pkg::FMT_DUMP) ? s.err[15:8]
					: dig(s.pos[0] ? s.err[11:8] : s.err[15:12]);
			record_fmt_pkg::FLD_TIME: r = time_byte(s);
			record_fmt_pkg::FLD_INDEX:
				r = dig(4'(s.idx >> (4 * (3 - int'(s.pos[1:0])))));
			record_fmt_pkg::FLD_SEP:
				r = (s.fmt == record_fmt_pkg::FMT_COMPRESSED) ? s.sep
					: record_fmt_pkg::CH_SPACE;
			record_fmt_pkg::FLD_TERM:
			begin
				if (s.on_bus && (s.term == record_fmt_pkg::TERM_NEWLINE))
				begin
					r = record_fmt_pkg::CH_LF;
				end
				else if (s.pos == 5'h00)
				begin
					r = record_fmt_pkg::CH_CR;
				end
				else if (s.pos == 5'h01)
				begin
					r = record_fmt_pkg::CH_LF;
				end
				else
				begin
					r = record_fmt_pkg::CH_NUL;
				end
			end
			record_fmt_pkg::FLD_HEAD_BASE:
			begin
				k = 8 * (int'(record_fmt_pkg::LEN_HEAD_BASE) - 1 - int'(s.pos));
				r = record_fmt_pkg::HEAD_BASE_TEXT[k +: 8];
			end
			record_fmt_pkg::FLD_HEAD_TIME:
			begin
				k = 8 * (int'(record_fmt_pkg::LEN_HEAD_TIME) - 1 - int'(s.pos));
				r = record_fmt_pkg::HEAD_TIME_TEXT[k +: 8];
			end
			record_fmt_pkg::FLD_HEAD_INDEX:
			begin
				k = 8 * (int'(record_fmt_pkg::LEN_HEAD_INDEX) - 1 - int'(s.pos));
				r = record_fmt_pkg::HEAD_INDEX_TEXT[k +: 8];
			end
			default: r = record_fmt_pkg::CH_SPACE;
		endcase
		return r;
	endfunction

	function automatic state_t add_fld(input state_t s,
		input record_fmt_pkg::field_t f);
		state_t r;
		r = s;
		r.fl[s.cnt[3:0]] = f;
		r.cnt = s.cnt + 5'h01;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic wr_en;
	logic start_req;
	logic ok;
	logic tab;
	logic list_idx;
	logic out_stall;
	logic last_byte;
	logic has_end_flag;
	logic [4:0] n;
	logic [2:0] bmode;
	logic [1:0] smode;
	logic short_sel;
	logic is_dump;
	record_fmt_pkg::fmt_t fsel;

	always_comb
	begin
		st_next = st_reg;
		short_sel = 1'b0;
		is_dump = 1'b0;
		fsel = record_fmt_pkg::FMT_TABLE;
		wr_en = wb_cyc_i && wb_stb_i && wb_we_i && st_reg.ack;
		start_req = 1'b0;
		ok = 1'b0;
		tab = 1'b0;
		list_idx = 1'b0;
		n = 5'h00;
		bmode = st_reg.ctrl[record_fmt_pkg::CTRL_BUS_MODE_LSB +: 3];
		smode = st_reg.ctrl[record_fmt_pkg::CTRL_SER_MODE_LSB +: 2];
		has_end_flag = (st_reg.term ==
			record_fmt_pkg::TERM_RETURN_WITH_END_FLAG) ||
			(st_reg.term == record_fmt_pkg::TERM_RETURN_NEWLINE_END_FLAG);
		// Registered ack: one wait cycle, then one cycle high, then low.
		st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
		st_next.dat = 32'h00000000;
		if (wb_cyc_i && wb_stb_i && !st_reg.ack && !wb_we_i)
		begin
			case (wb_adr_i)
				record_fmt_pkg::CTRL_OFS: st_next.dat = st_reg.ctrl;
				record_fmt_pkg::STATUS_OFS:
				begin
					st_next.dat[record_fmt_pkg::STATUS_BUSY_BIT] = st_reg.run ||
						st_reg.ser_valid || st_reg.bus_valid;
					st_next.dat[record_fmt_pkg::STATUS_REFUSED_BIT] =
						st_reg.refused;
					st_next.dat[record_fmt_pkg::STATUS_FIELD_LSB +: 5] = st_reg.fi;
				end
				record_fmt_pkg::FIRST_BIN_OFS: st_next.dat = st_reg.first_bin;
				record_fmt_pkg::SECOND_BIN_OFS: st_next.dat = st_reg.second_bin;
				record_fmt_pkg::FIRST_DEC_OFS: st_next.dat = st_reg.first_dec;
				record_fmt_pkg::SECOND_DEC_OFS: st_next.dat = st_reg.second_dec;
				record_fmt_pkg::ERRORS_OFS: st_next.dat = st_reg.err;
				record_fmt_pkg::TIME_OFS: st_next.dat = st_reg.tim;
				record_fmt_pkg::INDEX_OFS: st_next.dat = {16'h0000, st_reg.idx};
				default: st_next.dat = 32'h00000000;
			endcase
		end
		if (wr_en)
		begin
			case (wb_adr_i)
				record_fmt_pkg::CTRL_OFS:
				begin
					st_next.ctrl = merge(st_reg.ctrl, wb_dat_i, wb_sel_i);
					st_next.head_pend =
						st_next.ctrl[record_fmt_pkg::CTRL_HEAD_BIT];
				end
				record_fmt_pkg::STATUS_OFS:
				begin
					if (wb_sel_i[0] && wb_dat_i[record_fmt_pkg::STATUS_REFUSED_BIT])
					begin
						st_next.refused = 1'b0;
					end
				end
				record_fmt_pkg::FIRST_BIN_OFS:
					st_next.first_bin = merge(st_reg.first_bin, wb_dat_i, wb_sel_i);
				record_fmt_pkg::SECOND_BIN_OFS:
					st_next.second_bin = merge(st_reg.second_bin, wb_dat_i, wb_sel_i);
				record_fmt_pkg::FIRST_DEC_OFS:
					st_next.first_dec = merge(st_reg.first_dec, wb_dat_i, wb_sel_i);
				record_fmt_pkg::SECOND_DEC_OFS:
					st_next.second_dec = merge(st_reg.second_dec, wb_dat_i, wb_sel_i);
				record_fmt_pkg::ERRORS_OFS:
					st_next.err = merge(st_reg.err, wb_dat_i, wb_sel_i);
				record_fmt_pkg::TIME_OFS:
					st_next.tim = merge(st_reg.tim, wb_dat_i, wb_sel_i);
				record_fmt_pkg::INDEX_OFS:
					st_next.idx = 16'(merge({16'h0000, st_reg.idx}, wb_dat_i,
						wb_sel_i));
				record_fmt_pkg::START_OFS:
					start_req = wb_sel_i[0] && wb_dat_i[0];
				default: st_next.idx = st_reg.idx;
			endcase
		end

		// Output port: one byte per accepted transfer.
		out_stall = st_reg.on_bus ? (st_reg.bus_valid && !bus_ready_i)
			: (st_reg.ser_valid && !ser_ready_i);
		if (st_reg.bus_valid && bus_ready_i)
		begin
			st_next.bus_valid = 1'b0;
			st_next.bus_eoi = 1'b0;
		end
		if (st_reg.ser_valid && ser_ready_i)
		begin
			st_next.ser_valid = 1'b0;
		end
		last_byte = (st_reg.pos == len_of(st_reg) - 5'h01) &&
			(st_reg.fi == st_reg.cnt - 5'h01);
		if (st_reg.run && !out_stall)
		begin
			if (st_reg.on_bus)
			begin
				st_next.bus_data = byte_of(st_reg);
				st_next.bus_valid = 1'b1;
				st_next.bus_eoi = last_byte && has_end_flag;
			end
			else
			begin
				st_next.ser_data = byte_of(st_reg);
				st_next.ser_valid = 1'b1;
			end
			if (st_reg.pos == len_of(st_reg) - 5'h01)
			begin
				st_next.pos = 5'h00;
				st_next.fi = st_reg.fi + 5'h01;
				st_next.run = !last_byte;
			end
			else
			begin
				st_next.pos = st_reg.pos + 5'h01;
			end
		end

		// A new record starts only when the last one has fully drained.
		// A refused start leaves a sticky flag for software to clear.
		if (start_req)
		begin
			if (st_reg.ctrl[record_fmt_pkg::CTRL_PORT_BIT])
			begin
				ok = (bmode != 3'b000) && (bmode <= 3'b100);
				short_sel = (bmode == 3'b010) || (bmode == 3'b100);
				if (bmode >= 3'b011)
				begin
					fsel = record_fmt_pkg::FMT_DUMP;
				end
				else if (st_reg.ctrl[record_fmt_pkg::CTRL_TALK_ONLY_BIT])
				begin
					fsel = record_fmt_pkg::FMT_TABLE;
				end
				else
				begin
					fsel = record_fmt_pkg::FMT_COMPRESSED;
				end
			end
			else
			begin
				ok = (smode == 2'b01) || (smode == 2'b10);
				fsel = (smode == 2'b10) ? record_fmt_pkg::FMT_DUMP
					: record_fmt_pkg::FMT_TABLE;
				list_idx = (smode == 2'b01) &&
					st_reg.ctrl[record_fmt_pkg::CTRL_LIST_BIT];
			end
			is_dump = (fsel == record_fmt_pkg::FMT_DUMP);
			tab = (fsel == record_fmt_pkg::FMT_TABLE);
			if (st_reg.run || st_reg.ser_valid || st_reg.bus_valid || !ok)
			begin
				st_next.refused = 1'b1;
			end
			else
			begin
				st_next.on_bus = st_reg.ctrl[record_fmt_pkg::CTRL_PORT_BIT];
				st_next.fmt = fsel;
				st_next.term = record_fmt_pkg::term_t'(
					st_reg.ctrl[record_fmt_pkg::CTRL_TERM_LSB +: 3]);
				st_next.sep = st_reg.ctrl[record_fmt_pkg::CTRL_SEP_LSB +: 8];
				st_next.fi = 5'h00;
				st_next.pos = 5'h00;
				st_next.cnt = 5'h00;
				st_next.run = 1'b1;
				if (tab && st_reg.head_pend)
				begin
					st_next = add_fld(st_next, record_fmt_pkg::FLD_HEAD_BASE);
					if (!short_sel)
						st_next = add_fld(st_next, record_fmt_pkg::FLD_HEAD_TIME);
					if (list_idx)
						st_next = add_fld(st_next, record_fmt_pkg::FLD_HEAD_INDEX);
					st_next = add_fld(st_next, record_fmt_pkg::FLD_TERM);
					st_next.head_pend = 1'b0;
				end
				st_next = add_fld(st_next, record_fmt_pkg::FLD_FIRST);
				if (!is_dump)
					st_next = add_fld(st_next, record_fmt_pkg::FLD_SEP);
				st_next = add_fld(st_next, record_fmt_pkg::FLD_SECOND);
				if (!is_dump)
					st_next = add_fld(st_next, record_fmt_pkg::FLD_SEP);
				st_next = add_fld(st_next, record_fmt_pkg::FLD_ERR_ONE);
				if (!is_dump)
					st_next = add_fld(st_next, record_fmt_pkg::FLD_SEP);
				st_next = add_fld(st_next, record_fmt_pkg::FLD_ERR_TWO);
				if (!short_sel)
				begin
					if (!is_dump)
						st_next = add_fld(st_next, record_fmt_pkg::FLD_SEP);
					st_next = add_fld(st_next, record_fmt_pkg::FLD_TIME);
				end
				if (list_idx)
				begin
					st_next = add_fld(st_next, record_fmt_pkg::FLD_SEP);
					st_next = add_fld(st_next, record_fmt_pkg::FLD_INDEX);
				end
				if (!is_dump)
					st_next = add_fld(st_next, record_fmt_pkg::FLD_TERM);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= '0;
			st_reg.ctrl <= record_fmt_pkg::CTRL_RESET;
			st_reg.head_pend <=
				record_fmt_pkg::CTRL_RESET[record_fmt_pkg::CTRL_HEAD_BIT];
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.dat;
	assign wb_ack_o = st_reg.ack;
	assign ser_data_o = st_reg.ser_data;
	assign ser_valid_o = st_reg.ser_valid;
	assign bus_data_o = st_reg.bus_data;
	assign bus_valid_o = st_reg.bus_valid;
	assign bus_eoi_o = st_reg.bus_eoi;

endmodule

// File: tb/record_sink.sv
// Byte sink standing in for the printer or the bus controller.
`timescale 1ns/1ps

module record_sink
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	output logic ser_ready_o,
	output logic bus_ready_o
);
	// ------------------------------------------------------------
	// Ready generation
	// ------------------------------------------------------------
	// A slow sink stalls on a pseudo-random pattern to stress holding.
	logic [7:0] stall_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stall_reg <= 8'hA5;
			ser_ready_o <= 1'b0;
			bus_ready_o <= 1'b0;
		end
		else
		begin
			stall_reg <= {stall_reg[6:0], ^(stall_reg & 8'hB8)};
			ser_ready_o <= !slow_i || stall_reg[0];
			bus_ready_o <= !slow_i || stall_reg[1];
		end
	end
endmodule

// File: tb/result_record_formatter_props.sv
// Port assertions for the result record formatter.
`timescale 1ns/1ps

module result_record_formatter_props
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [7:0] ser_data_o,
	input wire logic ser_valid_o,
	input wire logic ser_ready_i,
	input wire logic [7:0] bus_data_o,
	input wire logic bus_valid_o,
	input wire logic bus_eoi_o,
	input wire logic bus_ready_i
);
	// ------------------------------------------------------------
	// Sequences and assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence bus_stall;
		bus_valid_o && !bus_ready_i;
	endsequence
	sequence bus_held;
		bus_valid_o && $stable(bus_data_o) && $stable(bus_eoi_o);
	endsequence
	sequence bus_last;
		bus_valid_o && bus_ready_i && bus_eoi_o;
	endsequence

	chk_bus_hold: assert property (bus_stall |=> bus_held)
		else $error("Bus byte changed while stalled.");
	chk_ser_hold: assert property (ser_valid_o && !ser_ready_i |=>
		ser_valid_o && $stable(ser_data_o))
		else $error("Serial byte changed while stalled.");
	chk_eoi_valid: assert property (bus_eoi_o |-> bus_valid_o)
		else $error("End flag without a bus byte.");
	chk_eoi_end: assert property (bus_last |=> !bus_valid_o)
		else $error("Bus byte follows the end of a record.");
	chk_port_one: assert property (!(bus_valid_o && ser_valid_o))
		else $error("Both ports offer a byte.");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("Acknowledge without a request.");
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held too long.");
	chk_ack_soon: assert property ($rose(wb_stb_i) |-> ##[1:16] wb_ack_o)
		else $error("Register request not answered.");
	chk_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !bus_valid_o && !ser_valid_o && !wb_ack_o)
		else $error("Outputs busy after reset.");
endmodule

// File: tb/test_result_record_formatter.sv
// Self-checking testbench of the result record formatter.
`timescale 1ns/1ps

module test_result_record_formatter;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h00000000;
	logic [31:0] wb_rdat;
	logic [31:0] rd_val;
	logic wb_ack, ser_valid, ser_ready, bus_valid, bus_eoi, bus_ready;
	logic [7:0] ser_data, bus_data;
	logic slow = 1'b0;
	logic [15:0] seed = 16'h8261;
	logic [9:0] exp_q[$];
	int bad_count = 0;
	int cmp_count = 0;

	always #5 clk_i = ~clk_i;

	result_record_formatter #(.NUL_PAD(2)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
		.wb_sel_i(4'hF), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.ser_data_o(ser_data), .ser_valid_o(ser_valid),
		.ser_ready_i(ser_ready), .bus_data_o(bus_data),
		.bus_valid_o(bus_valid), .bus_eoi_o(bus_eoi),
		.bus_ready_i(bus_ready));

	record_sink sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.ser_ready_o(ser_ready), .bus_ready_o(bus_ready));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [7:0] bcd(input int v);
		return {4'(v / 10 % 10), 4'(v % 10)};
	endfunction

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Classic single cycle; ack and read data are taken at the edge
	// that samples ack high, and only then is the request released.
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 50);
		if (wb_ack !== 1'b1)
			check("register ack", 32'h1, 32'h0);
		rd_val = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	// Monitor: each accepted byte is matched with the oldest note.
	always @(negedge clk_i)
	begin
		if (!rst_i && bus_valid === 1'b1 && bus_ready === 1'b1)
			take({1'b0, bus_eoi, bus_data});
		if (!rst_i && ser_valid === 1'b1 && ser_ready === 1'b1)
			take({1'b1, 1'b0, ser_data});
	end

	task automatic take(input logic [9:0] seen);
		if (exp_q.size() == 0)
			check("extra byte", 32'h0, {22'h0, seen});
		else
			check("record byte", {22'h0, exp_q.pop_front()}, {22'h0, seen});
	endtask

	task automatic send(input logic [31:0] ctrl, input logic port,
		input logic short_rec, input logic eoi_on, input logic [31:0] p1);
		logic [31:0] p2, er, tm;
		logic [7:0] b[$];
		int n;
		seed = lfsr(seed);
		p2 = {seed, ~seed};
		er = {16'h0000, bcd(seed / 100 % 100), bcd(seed % 100)};
		tm = {bcd(seed % 24), bcd(seed % 60), bcd(seed / 60 % 60),
			bcd(seed / 7 % 100)};
		b = {p1[31:24], p1[23:16], p1[15:8], p1[7:0], p2[31:24], p2[23:16],
			p2[15:8], p2[7:0], er[7:0], er[15:8]};
		if (!short_rec)
			b = {b, tm[31:24], tm[23:16], tm[15:8], tm[7:0]};
		wb(1'b1, record_fmt_pkg::CTRL_OFS, ctrl);
		wb(1'b1, record_fmt_pkg::FIRST_BIN_OFS, p1);
		wb(1'b1, record_fmt_pkg::SECOND_BIN_OFS, p2);
		wb(1'b1, record_fmt_pkg::ERRORS_OFS, er);
		wb(1'b1, record_fmt_pkg::TIME_OFS, tm);
		foreach (b[i])
			exp_q.push_back({port, eoi_on && i == b.size() - 1, b[i]});
		wb(1'b1, record_fmt_pkg::START_OFS, 32'h00000001);
		n = 0;
		while (exp_q.size() != 0 && n < 2000)
		begin
			@(posedge clk_i);
			n++;
		end
		check("record done", 32'h0, exp_q.size());
		repeat (6) @(posedge clk_i);
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, record_fmt_pkg::CTRL_OFS, 32'h0);
		check("ctrl reset", record_fmt_pkg::CTRL_RESET, rd_val);
		wb(1'b0, record_fmt_pkg::FIRST_BIN_OFS, 32'h0);
		check("data reset", record_fmt_pkg::DATA_RESET, rd_val);
		wb(1'b0, 8'h40, 32'h0);
		$display("Test registers done.");
		for (int t = 0; t < 5; t++)
		begin
			slow <= t[0];
			seed = lfsr(seed);
			send(32'h002C0103 | (32'(t) << 12), 1'b0, 1'b0, t >= 3,
				{seed, lfsr(seed)});
		end
		$display("Test long dump done.");
		slow <= 1'b1;
		send(32'h002C4104, 1'b0, 1'b1, 1'b1, 32'hFE800000);
		$display("Test short dump done.");
		seed = lfsr(seed);
		send(32'h002C0010, 1'b1, 1'b0, 1'b0, {lfsr(seed), seed});
		$display("Test serial dump done.");
		stop_test;
	end

	initial
	begin
		repeat (80000) @(posedge clk_i);
		check("watchdog", 32'h0, 32'h1);
		stop_test;
	end
endmodule

bind result_record_formatter result_record_formatter_props props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ser_data_o(ser_data_o),
	.ser_valid_o(ser_valid_o), .ser_ready_i(ser_ready_i),
	.bus_data_o(bus_data_o), .bus_valid_o(bus_valid_o),
	.bus_eoi_o(bus_eoi_o), .bus_ready_i(bus_ready_i));
